// ===== src/rsr_pkg.sv
/*
 * Shared constants for the rate sensor serial readout: register map,
 * frame layout and timing counts for both the sensor end and the host end.
 * Assumes a 40 MHz system clock on both ends.
 */
// Functional notes
// R1: sensor changes output bit on clock fall
// R2: sensor captures input bit on clock rise
// R3: mode 3, clock idles high, MSB first
// R4: host keeps serial clock at most 2.5 MHz
// R5: read takes two frames, answer second
// R6: full duplex: answer old, take new
// R7: answer driven only after read request
// R8: output released while select is high
// R9: read word: address high byte, zero low
// R10: sensor samples on its own after reset
// R11: sensor pulses data ready each sample
// R12: rate high at 0x06, low at 0x04
// R13: rate high word two's complement, zero 0
// R14: low word MSB-justified, decimation bits valid
// R15: temperature word at 0x02, two's complement
// R16: registers 16 bits, low byte even address
// R17: write frame: bit one, address, data byte
// R18: answer word captured at frame start
package rsr_pkg;
    localparam int          FRAME_BITS    = 16;
    localparam int          ADDR_W        = 7;
    localparam int          RW_BIT        = 15;
    localparam int          ADDR_MSB      = 14;
    localparam int          ADDR_LSB      = 8;
    localparam int          DATA_MSB      = 7;
    localparam logic [6:0]  ADDR_TEMP     = 7'h02;
    localparam logic [6:0]  ADDR_RATE_LO  = 7'h04;
    localparam logic [6:0]  ADDR_RATE_HI  = 7'h06;
    localparam logic [6:0]  ADDR_DEC      = 7'h22;
    localparam int          DEC_W         = 5;
    localparam logic [4:0]  DEC_RESET     = 5'h00;
    localparam logic [15:0] WORD_RESET    = 16'h0000;
    // timing
    localparam int CLK_PERIOD_NS    = 25;
    localparam int SCLK_MAX_KHZ     = 2500;
    localparam int SCLK_HALF_CYCLES =
        (1000000 + 2 * SCLK_MAX_KHZ * CLK_PERIOD_NS - 1) / (2 * SCLK_MAX_KHZ * CLK_PERIOD_NS);
    localparam int STALL_NS         = 15000;
    localparam int STALL_CYCLES     = (STALL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SAMPLE_PERIOD_NS = 488281;
    localparam int SAMPLE_CYCLES    = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
    localparam int DRDY_CYCLES      = 4;
    // host register map (APB byte addresses)
    localparam logic [7:0] REG_CMD      = 8'h00;
    localparam logic [7:0] REG_STATUS   = 8'h04;
    localparam logic [7:0] REG_RXDATA   = 8'h08;
    localparam logic [7:0] REG_INT_STAT = 8'h0c;
    localparam logic [7:0] REG_INT_CLR  = 8'h10;
    localparam logic [7:0] REG_INT_EN   = 8'h14;
    localparam int         INT_W        = 2;
    localparam int         INT_FRAME    = 0;
    localparam int         INT_DRDY     = 1;
endpackage : rsr_pkg

// ===== src/rsr_spi_if.sv
/*
 * Serial link between the rate sensor and its host.
 * The shared data-out line is modelled with a pull-up when released.
 */
`timescale 1ns/100ps
interface rsr_spi_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;
    logic miso_oe_n;
    logic drdy;
    logic miso_line;

    assign miso_line = miso_oe_n ? 1'b1 : miso;

    modport dev  (input sclk, input cs_n, input mosi,
                  output miso, output miso_oe_n, output drdy);
    modport host (output sclk, output cs_n, output mosi,
                  input miso_line, input drdy);
endinterface : rsr_spi_if

// ===== src/rsr_sensor.sv
/*
 * Sensor end: serial slave port, output data registers, sample timer.
 * Assumes the host keeps each clock half period well above the
 * two-cycle synchroniser latency of this end.
 */
`timescale 1ns/100ps
module rsr_sensor
    import rsr_pkg::*;
#(
    parameter int SAMPLE_CYC = SAMPLE_CYCLES,
    parameter int DRDY_CYC   = DRDY_CYCLES
) (
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        resetn_i,
    // link
    rsr_spi_if.dev           spi,
    // measurement inputs
    input  wire logic [31:0] rate_i,
    input  wire logic [15:0] temp_i,
    // state
    output logic [4:0]       decimation_factor_field_o,
    output logic [15:0]      rate_result_high_word_o
);
    // synchronisers
    logic [1:0] sclk_sync_reg, cs_sync_reg, mosi_sync_reg;
    logic       sclk_prev_reg, cs_prev_reg;

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sclk_sync_reg <= 2'h3;
            cs_sync_reg   <= 2'h3;
            mosi_sync_reg <= 2'h0;
            sclk_prev_reg <= 1'b1;
            cs_prev_reg   <= 1'b1;
        end else begin
            sclk_sync_reg <= {sclk_sync_reg[0], spi.sclk};
            cs_sync_reg   <= {cs_sync_reg[0], spi.cs_n};
            mosi_sync_reg <= {mosi_sync_reg[0], spi.mosi};
            sclk_prev_reg <= sclk_sync_reg[1];
            cs_prev_reg   <= cs_sync_reg[1];
        end
    end

    logic sclk_s, cs_s, mosi_s;
    logic sclk_rise, sclk_fall, frame_start, frame_end;

    assign sclk_s      = sclk_sync_reg[1];
    assign cs_s        = cs_sync_reg[1];
    assign mosi_s      = mosi_sync_reg[1];
    assign sclk_rise   = sclk_s & ~sclk_prev_reg;
    assign sclk_fall   = ~sclk_s & sclk_prev_reg;
    assign frame_start = ~cs_s & cs_prev_reg;
    assign frame_end   = cs_s & ~cs_prev_reg;

    // sample engine
    logic [31:0] sample_cnt_reg, sample_cnt_next;
    logic [7:0]  drdy_cnt_reg, drdy_cnt_next;
    logic        drdy_reg, drdy_next;
    logic [15:0] temp_reg, temp_next;
    logic [15:0] rate_lo_reg, rate_lo_next;
    logic [15:0] rate_hi_reg, rate_hi_next;
    logic [4:0]  dec_reg, dec_next;
    logic [15:0] lo_mask;

    // only the top dec_reg bits of the low word carry resolution
    assign lo_mask = ~(16'hffff >> dec_reg);

    always_comb begin
        sample_cnt_next = sample_cnt_reg + 32'h1;
        drdy_cnt_next   = drdy_cnt_reg;
        drdy_next       = drdy_reg;
        temp_next       = temp_reg;
        rate_lo_next    = rate_lo_reg;
        rate_hi_next    = rate_hi_reg;
        if (drdy_reg) begin
            if (drdy_cnt_reg == 8'(DRDY_CYC - 1)) begin
                drdy_next     = 1'b0;
                drdy_cnt_next = 8'h0;
            end else begin
                drdy_cnt_next = drdy_cnt_reg + 8'h1;
            end
        end
        if (sample_cnt_reg == 32'(SAMPLE_CYC - 1)) begin // [R10]
            sample_cnt_next = 32'h0;
            rate_hi_next    = rate_i[31:16];              // [R12] [R13]
            rate_lo_next    = rate_i[15:0] & lo_mask;     // [R14]
            temp_next       = temp_i;                     // [R15]
            drdy_next       = 1'b1;                       // [R11]
            drdy_cnt_next   = 8'h0;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sample_cnt_reg <= 32'h0;
            drdy_cnt_reg   <= 8'h0;
            drdy_reg       <= 1'b0;
            temp_reg       <= WORD_RESET;
            rate_lo_reg    <= WORD_RESET;
            rate_hi_reg    <= WORD_RESET;
        end else begin
            sample_cnt_reg <= sample_cnt_next;
            drdy_cnt_reg   <= drdy_cnt_next;
            drdy_reg       <= drdy_next;
            temp_reg       <= temp_next;
            rate_lo_reg    <= rate_lo_next;
            rate_hi_reg    <= rate_hi_next;
        end
    end

    // register read selection, 16-bit words at even addresses
    function automatic logic [15:0] read_word(input logic [6:0] addr);
        logic [6:0] base;
        base = {addr[6:1], 1'b0};                         // [R16]
        case (base)
            ADDR_TEMP:    read_word = temp_reg;
            ADDR_RATE_LO: read_word = rate_lo_reg;
            ADDR_RATE_HI: read_word = rate_hi_reg;
            ADDR_DEC:     read_word = {11'h0, dec_reg};
            default:      read_word = WORD_RESET;
        endcase
    endfunction : read_word

    // serial port
    logic [15:0] rx_reg, rx_next;
    logic [15:0] tx_reg, tx_next;
    logic [4:0]  bit_cnt_reg, bit_cnt_next;
    logic        pend_reg, pend_next;
    logic [6:0]  pend_addr_reg, pend_addr_next;
    logic        miso_reg, miso_next;
    logic        oe_n_reg, oe_n_next;
    logic [15:0] rx_word;

    assign rx_word = {rx_reg[14:0], mosi_s};

    always_comb begin
        rx_next        = rx_reg;
        tx_next        = tx_reg;
        bit_cnt_next   = bit_cnt_reg;
        pend_next      = pend_reg;
        pend_addr_next = pend_addr_reg;
        miso_next      = miso_reg;
        oe_n_next      = oe_n_reg;
        dec_next       = dec_reg;
        if (frame_start) begin
            bit_cnt_next = 5'h0;
            tx_next      = read_word(pend_addr_reg);      // [R18] [R5]
            oe_n_next    = ~pend_reg;                     // [R7]
            pend_next    = 1'b0;
        end else if (frame_end) begin
            oe_n_next = 1'b1;                             // [R8]
        end else if (!cs_s) begin
            if (sclk_fall && !oe_n_reg) begin
                miso_next = tx_reg[15];                   // [R1] [R3]
                tx_next   = {tx_reg[14:0], 1'b0};
            end
            if (sclk_rise && bit_cnt_reg != 5'(FRAME_BITS)) begin
                rx_next      = rx_word;                   // [R2]
                bit_cnt_next = bit_cnt_reg + 5'h1;
                if (bit_cnt_reg == 5'(FRAME_BITS - 1)) begin
                    if (!rx_word[RW_BIT]) begin
                        pend_next      = 1'b1;            // [R6]
                        pend_addr_next = rx_word[ADDR_MSB:ADDR_LSB];
                    end else if (rx_word[ADDR_MSB:ADDR_LSB] == ADDR_DEC) begin
                        dec_next = rx_word[DEC_W-1:0];    // [R17]
                    end
                end
            end
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_reg        <= WORD_RESET;
            tx_reg        <= WORD_RESET;
            bit_cnt_reg   <= 5'h0;
            pend_reg      <= 1'b0;
            pend_addr_reg <= 7'h0;
            miso_reg      <= 1'b1;
            oe_n_reg      <= 1'b1;
            dec_reg       <= DEC_RESET;
        end else begin
            rx_reg        <= rx_next;
            tx_reg        <= tx_next;
            bit_cnt_reg   <= bit_cnt_next;
            pend_reg      <= pend_next;
            pend_addr_reg <= pend_addr_next;
            miso_reg      <= miso_next;
            oe_n_reg      <= oe_n_next;
            dec_reg       <= dec_next;
        end
    end

    assign spi.miso                  = miso_reg;
    assign spi.miso_oe_n             = oe_n_reg;
    assign spi.drdy                  = drdy_reg;
    assign decimation_factor_field_o = dec_reg;
    assign rate_result_high_word_o   = rate_hi_reg;
endmodule : rsr_sensor

// ===== src/rsr_host.sv
/*
 * Host end: APB-programmed serial master for the rate sensor.
 * Assumes software writes one frame word at a time and polls busy before
 * the next; the frame interrupt rises as the stall begins, and command writes are ignored until it ends.
 */
`timescale 1ns/100ps
module rsr_host
    import rsr_pkg::*;
#(
    parameter int HALF_CYC  = SCLK_HALF_CYCLES,
    parameter int STALL_CYC = STALL_CYCLES
) (
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        resetn_i,
    // link
    rsr_spi_if.host          spi,
    // apb slave
    input  wire logic [7:0]  paddr_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // interrupt
    output logic             irq_o
);
    typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_SHIFT, ST_TAIL, ST_STALL} rsr_state_e;

    logic [1:0] miso_sync_reg, drdy_sync_reg;
    logic       drdy_prev_reg;

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            miso_sync_reg <= 2'h3;
            drdy_sync_reg <= 2'h0;
            drdy_prev_reg <= 1'b0;
        end else begin
            miso_sync_reg <= {miso_sync_reg[0], spi.miso_line};
            drdy_sync_reg <= {drdy_sync_reg[0], spi.drdy};
            drdy_prev_reg <= drdy_sync_reg[1];
        end
    end

    rsr_state_e  state_reg, state_next;
    logic [15:0] cnt_reg, cnt_next;
    logic [4:0]  bits_reg, bits_next;
    logic [15:0] tx_reg, tx_next;
    logic [15:0] rx_reg, rx_next;
    logic [15:0] cmd_reg, cmd_next;
    logic        sclk_reg, sclk_next;
    logic        cs_n_reg, cs_n_next;
    logic        mosi_reg, mosi_next;
    logic [1:0]  ist_reg, ist_next;
    logic [1:0]  ien_reg, ien_next;
    logic [31:0] prdata_reg, prdata_next;
    logic        pready_reg, pready_next;
    logic        irq_reg, irq_next;
    logic        wr_en, setup, tick, frame_done;
    logic [1:0]  ev;

    assign setup = psel_i & ~penable_i;
    assign wr_en = psel_i & penable_i & pready_reg & pwrite_i;
    assign tick  = (cnt_reg == 16'(HALF_CYC - 1));

    always_comb begin
        state_next = state_reg;
        cnt_next   = tick ? 16'h0 : cnt_reg + 16'h1;
        bits_next  = bits_reg;
        tx_next    = tx_reg;
        rx_next    = rx_reg;
        cmd_next   = cmd_reg;
        sclk_next  = sclk_reg;
        cs_n_next  = cs_n_reg;
        mosi_next  = mosi_reg;
        frame_done = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                cnt_next = 16'h0;
                if (wr_en && paddr_i == REG_CMD) begin
                    cmd_next   = pwdata_i[15:0];          // [R9] [R17]
                    tx_next    = pwdata_i[15:0];
                    cs_n_next  = 1'b0;
                    bits_next  = 5'h0;
                    state_next = ST_LEAD;
                end
            end
            ST_LEAD: if (tick) state_next = ST_SHIFT;
            ST_SHIFT: begin
                if (tick) begin                           // [R4]
                    if (sclk_reg) begin
                        sclk_next = 1'b0;
                        mosi_next = tx_reg[15];           // [R3]
                        tx_next   = {tx_reg[14:0], 1'b0};
                    end else begin
                        sclk_next = 1'b1;
                        rx_next   = {rx_reg[14:0], miso_sync_reg[1]}; // [R6]
                        bits_next = bits_reg + 5'h1;
                        if (bits_reg == 5'(FRAME_BITS - 1)) state_next = ST_TAIL;
                    end
                end
            end
            ST_TAIL: begin
                if (tick) begin
                    cs_n_next  = 1'b1;
                    frame_done = 1'b1;
                    state_next = ST_STALL;
                end
            end
            ST_STALL: begin
                cnt_next = cnt_reg + 16'h1;
                if (cnt_reg == 16'(STALL_CYC - 1)) begin
                    cnt_next   = 16'h0;
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always_comb begin
        ev          = 2'h0;
        ev[INT_FRAME] = frame_done;
        ev[INT_DRDY]  = drdy_sync_reg[1] & ~drdy_prev_reg;
        ist_next    = ist_reg;
        ien_next    = ien_reg;
        if (wr_en && paddr_i == REG_INT_CLR) ist_next = ist_reg & ~pwdata_i[INT_W-1:0];
        if (wr_en && paddr_i == REG_INT_EN) ien_next = pwdata_i[INT_W-1:0];
        ist_next    = ist_next | ev;
        irq_next    = |(ist_next & ien_next);
        pready_next = setup;
        prdata_next = 32'h0;
        if (setup && !pwrite_i) begin
            case (paddr_i)
                REG_CMD:      prdata_next = {16'h0, cmd_reg};
                REG_STATUS:   prdata_next = {31'h0, state_reg != ST_IDLE};
                REG_RXDATA:   prdata_next = {16'h0, rx_reg};
                REG_INT_STAT: prdata_next = {30'h0, ist_reg};
                REG_INT_EN:   prdata_next = {30'h0, ien_reg};
                default:      prdata_next = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg  <= ST_IDLE;
            cnt_reg    <= 16'h0;
            bits_reg   <= 5'h0;
            tx_reg     <= WORD_RESET;
            rx_reg     <= WORD_RESET;
            cmd_reg    <= WORD_RESET;
            sclk_reg   <= 1'b1;
            cs_n_reg   <= 1'b1;
            mosi_reg   <= 1'b1;
            ist_reg    <= 2'h0;
            ien_reg    <= 2'h0;
            prdata_reg <= 32'h0;
            pready_reg <= 1'b0;
            irq_reg    <= 1'b0;
        end else begin
            state_reg  <= state_next;
            cnt_reg    <= cnt_next;
            bits_reg   <= bits_next;
            tx_reg     <= tx_next;
            rx_reg     <= rx_next;
            cmd_reg    <= cmd_next;
            sclk_reg   <= sclk_next;
            cs_n_reg   <= cs_n_next;
            mosi_reg   <= mosi_next;
            ist_reg    <= ist_next;
            ien_reg    <= ien_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            irq_reg    <= irq_next;
        end
    end

    assign spi.sclk  = sclk_reg;
    assign spi.cs_n  = cs_n_reg;
    assign spi.mosi  = mosi_reg;
    assign prdata_o  = prdata_reg;
    assign pready_o  = pready_reg;
    assign pslverr_o = 1'b0;
    assign irq_o     = irq_reg;
endmodule : rsr_host

// ===== bench/rsr_checker_sva.sv
/*
 * Link checker: frame shape, output release, answer gating, data-ready pulse.
 * Assumes a host half period of 8 cycles and the sample period handed in.
 */
`timescale 1ns/100ps
module rsr_checker #(
    parameter int SAMPLE_CYC = 200
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe_n,
    input wire logic drdy
);
    localparam int P_LO = SAMPLE_CYC - 1;
    localparam int P_HI = SAMPLE_CYC + 1;
    logic       sclk_reg;
    logic       cs_reg;
    logic [4:0] rise_reg;
    logic [4:0] rise_next;
    logic       first_reg;
    logic       first_next;
    logic       rd_reg;
    logic       rd_next;

    // rises per frame, first input bit, and whether the last frame was a read
    always_comb begin
        rise_next  = rise_reg;
        first_next = first_reg;
        rd_next    = rd_reg;
        if (cs_n) begin
            rise_next = 5'h00;
        end else if (sclk && !sclk_reg) begin
            rise_next = rise_reg + 5'h01;
            if (rise_reg == 5'h00) begin
                first_next = mosi;
            end
        end
        if (cs_n && !cs_reg) begin
            rd_next = (rise_reg == 5'h10) && !first_reg;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sclk_reg  <= 1'b1;
            cs_reg    <= 1'b1;
            rise_reg  <= 5'h00;
            first_reg <= 1'b1;
            rd_reg    <= 1'b0;
        end else begin
            sclk_reg  <= sclk;
            cs_reg    <= cs_n;
            rise_reg  <= rise_next;
            first_reg <= first_next;
            rd_reg    <= rd_next;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    sequence s_drdy_pulse;
        drdy [*4] ##1 !drdy;
    endsequence
    // the host holds the clock high for a lead state and a first half period
    sequence s_lead;
        sclk [*8] ##1 sclk [*8] ##1 !sclk;
    endsequence

    a_oe_idle: assert property (cs_n [*6] |-> miso_oe_n)
        else $error("data out driven while deselected");
    a_sclk_idle: assert property (cs_n |-> sclk)
        else $error("serial clock low outside a frame");
    a_cs_lead: assert property ($fell(cs_n) |-> s_lead)
        else $error("serial clock lead after select wrong");
    a_sclk_half: assert property ($changed(sclk) |=> $stable(sclk) [*7])
        else $error("serial clock half period too short");
    a_miso_on_fall: assert property (!cs_n && !miso_oe_n && !$past(miso_oe_n) && $changed(miso)
        |-> !sclk)
        else $error("data out changed while clock high");
    a_mosi_hold: assert property (!cs_n && $rose(sclk) |-> $stable(mosi) [*4])
        else $error("data in moved around the rising edge");
    a_frame_bits: assert property ($rose(cs_n) |-> rise_reg == 5'h10)
        else $error("frame without sixteen clocks");
    a_answer_gate: assert property (!cs_n && !rd_reg |-> miso_oe_n)
        else $error("data out driven without a read request");
    a_drdy_width: assert property ($rose(drdy) |-> s_drdy_pulse)
        else $error("data ready pulse width wrong");
    a_drdy_period: assert property ($rose(drdy) |-> ##[P_LO:P_HI] $rose(drdy))
        else $error("data ready period wrong");
endmodule : rsr_checker

// ===== bench/tb_rate_sensor_spi_readout.sv
/*
 * Bench: host and sensor joined by the link, host driven over apb.
 * Assumes shortened sample and stall counts set at the instances.
 */
`timescale 1ns/100ps
module tb_rate_sensor_spi_readout;
    import rsr_pkg::*;
    localparam int SAMPLE_C = 200;
    logic        clock_i   = 1'b0;
    logic        resetn_i  = 1'b0;
    logic [31:0] rate_i    = '0;
    logic [15:0] temp_i    = '0;
    logic [7:0]  paddr_i   = '0;
    logic        psel_i    = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i  = 1'b0;
    logic [31:0] pwdata_i  = '0;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic        irq_o;
    logic [4:0]  dec_o;
    logic [15:0] hi_o;
    logic [15:0] mosi_w;
    logic [15:0] miso_w;
    logic [15:0] prev_req;
    logic [4:0]  dec;
    logic        sclk_q;
    int          n_errors = 0;
    int          checks   = 0;
    logic [7:0]  rmap [5] = '{REG_STATUS, REG_RXDATA, REG_INT_STAT, REG_INT_EN, 8'h18};
    logic [15:0] reqs [7] = '{16'h0600, 16'h0400, 16'h0200, 16'h0700, 16'h2200, 16'h1000,
                              16'h0600};

    always #12.5 clock_i = ~clock_i;

    rsr_spi_if i_rsr_spi_if ();
    rsr_sensor #(.SAMPLE_CYC(SAMPLE_C), .DRDY_CYC(4)) i_rsr_sensor (
        .clock_i(clock_i), .resetn_i(resetn_i), .spi(i_rsr_spi_if), .rate_i(rate_i),
        .temp_i(temp_i), .decimation_factor_field_o(dec_o), .rate_result_high_word_o(hi_o));
    rsr_host #(.HALF_CYC(8), .STALL_CYC(20)) i_rsr_host (
        .clock_i(clock_i), .resetn_i(resetn_i), .spi(i_rsr_spi_if), .paddr_i(paddr_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o));
    rsr_checker #(.SAMPLE_CYC(SAMPLE_C)) i_rsr_checker (
        .clock_i(clock_i), .resetn_i(resetn_i), .sclk(i_rsr_spi_if.sclk),
        .cs_n(i_rsr_spi_if.cs_n), .mosi(i_rsr_spi_if.mosi), .miso(i_rsr_spi_if.miso),
        .miso_oe_n(i_rsr_spi_if.miso_oe_n), .drdy(i_rsr_spi_if.drdy));

    // words seen on the wire, shifted in at each serial clock rise
    always @(posedge clock_i) begin
        sclk_q <= i_rsr_spi_if.sclk;
        if (i_rsr_spi_if.cs_n === 1'b0 && i_rsr_spi_if.sclk && !sclk_q) begin
            mosi_w <= {mosi_w[14:0], i_rsr_spi_if.mosi};
            miso_w <= {miso_w[14:0], i_rsr_spi_if.miso_line};
        end
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d, output logic [31:0] q);
        psel_i   <= 1'b1;
        paddr_i  <= a;
        pwrite_i <= wr;
        pwdata_i <= d;
        @(posedge clock_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clock_i);
        end while (pready_o !== 1'b1);
        q = prdata_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clock_i);
    endtask : apb

    task automatic wait_idle();
        logic [31:0] q;
        int n;
        n = 0;
        do begin
            apb(1'b0, REG_STATUS, 32'h0, q);
            n++;
        end while (q[0] !== 1'b0 && n < 400);
        if (n >= 400) n_errors++;
    endtask : wait_idle

    task automatic wait_drdy();
        int n;
        n = 0;
        while (i_rsr_spi_if.drdy !== 1'b0 && n < 500) begin
            @(posedge clock_i);
            n++;
        end
        while (i_rsr_spi_if.drdy !== 1'b1 && n < 500) begin
            @(posedge clock_i);
            n++;
        end
        if (n >= 500) n_errors++;
    endtask : wait_drdy

    function automatic logic [15:0] answer(logic [15:0] r, logic [4:0] d);
        if (r[15]) return 16'hffff;
        case (r[14:8] & 7'h7e)
            ADDR_TEMP:    return temp_i;
            ADDR_RATE_LO: return rate_i[15:0] & ~(16'hffff >> d);
            ADDR_RATE_HI: return rate_i[31:16];
            ADDR_DEC:     return {11'h000, d};
            default:      return 16'h0000;
        endcase
    endfunction : answer

    // one frame: expected answer belongs to the previous request
    task automatic rq(logic [15:0] w);
        logic [31:0] q;
        logic [15:0] e;
        e = answer(prev_req, dec);
        apb(1'b1, REG_CMD, {16'h0000, w}, q);
        wait_idle();
        apb(1'b0, REG_RXDATA, 32'h0, q);
        check("mosi word", {16'h0000, mosi_w}, {16'h0000, w});
        check("rx word", q, {16'h0000, e});
        check("miso word", {16'h0000, miso_w}, {16'h0000, e});
        prev_req = w;
        if (w[15] && w[14:8] == ADDR_DEC) begin
            dec = w[4:0];
            check("decimation", {27'h0, dec_o}, {27'h0, dec});
        end
    endtask : rq

    initial begin
        logic [31:0] q;
        int k;
        void'($urandom(32'h5378));
        prev_req = 16'h8000;
        dec = DEC_RESET;
        repeat (5) @(posedge clock_i);
        resetn_i <= 1'b1;
        @(posedge clock_i);
        apb(1'b1, 8'h18, 32'hffff_ffff, q);
        foreach (rmap[i]) begin
            apb(1'b0, rmap[i], 32'h0, q);
            check("reset reg", q, 32'h0);
        end
        check("dec reset", {27'h0, dec_o}, 32'h0);
        $display("test reset done");
        apb(1'b1, REG_INT_CLR, 32'h3, q);
        apb(1'b1, REG_CMD, 32'h0000_0600, q);
        apb(1'b1, REG_CMD, 32'h0000_0200, q);
        apb(1'b0, REG_STATUS, 32'h0, q);
        check("busy", {31'h0, q[0]}, 32'h1);
        wait_idle();
        check("held word", {16'h0000, mosi_w}, 32'h0600);
        prev_req = 16'h0600;
        apb(1'b0, REG_INT_STAT, 32'h0, q);
        check("frame flag", {31'h0, q[0]}, 32'h1);
        check("irq masked", {31'h0, irq_o}, 32'h0);
        apb(1'b1, REG_INT_EN, 32'h1, q);
        apb(1'b0, REG_INT_EN, 32'h0, q);
        check("irq enable", q, 32'h1);
        check("irq raised", {31'h0, irq_o}, 32'h1);
        apb(1'b1, REG_INT_CLR, 32'h3, q);
        apb(1'b0, REG_INT_STAT, 32'h0, q);
        check("frame flag clr", {31'h0, q[0]}, 32'h0);
        check("irq cleared", {31'h0, irq_o}, 32'h0);
        wait_drdy();
        // the host sees the pulse through its synchroniser a few cycles later
        repeat (3) @(posedge clock_i);
        apb(1'b0, REG_INT_STAT, 32'h0, q);
        check("drdy flag", {31'h0, q[1]}, 32'h1);
        $display("test interrupt done");
        for (k = 0; k < 4; k++) begin
            rate_i <= (k == 0) ? 32'h8000_ffff : $urandom();
            temp_i <= (k == 0) ? 16'hf165 : 16'($urandom());
            // a sample at this very edge would still take the old inputs
            @(posedge clock_i);
            wait_drdy();
            rq({1'b1, ADDR_DEC, 3'b000, (k == 0) ? 5'h03 : 5'($urandom_range(16))});
            wait_drdy();
            check("rate high", {16'h0000, hi_o}, {16'h0000, rate_i[31:16]});
            foreach (reqs[i]) begin
                rq(reqs[i]);
            end
            $display("test readout %0d done", k);
        end
        wrap_up();
    end

    initial begin
        repeat (60000) @(posedge clock_i);
        n_errors++;
        wrap_up();
    end
endmodule : tb_rate_sensor_spi_readout
